// ---- tsi_top.v ----
// Added by the designer: the register addresses and the APB slave port.
`include "tsi_defs.vh"
`default_nettype none

module tsi_top #(
  parameter NV_WRITE_CYCLES = `TSI_NV_WRITE_NS / `TSI_CLK_NS
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // host control pins
  input wire measure_request,
  input wire config_entry_n,
  input wire reset_n,
  input wire serial_select_n,
  // sensing front end
  input wire [7:0] sense_electrode_pin,
  input wire [3:0] shared_charge_pin_in,
  output reg [3:0] shared_charge_pin_out,
  output reg [3:0] shared_charge_pin_oe,
  // result outputs
  output reg [7:0] channel_result_out,
  output reg status_indicator_out,
  output wire irq
);

  // measurement phase length in clocks
  localparam PHASE_CYCLES = (`TSI_PHASE_NS + `TSI_CLK_NS - 1) / `TSI_CLK_NS;

  // top states
  localparam ST_LOAD = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_SETUP = 2'd2;

  // internal registers and decoded terms
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [15:0] cfg_r;
  reg [7:0] ch_en_r;
  reg [7:0] touch_r;
  reg [7:0] touch_nxt;
  reg [`TSI_EV_W-1:0] irq_stat_r;
  reg [`TSI_EV_W-1:0] irq_en_r;
  reg [15:0] phase_cnt_r;
  reg phase_r;
  reg measure_request_done;
  reg touch_chg;
  reg ind_pend_r;
  reg [`TSI_EV_W-1:0] events;
  reg [31:0] status_word;

  // mode and measurement qualifiers
  wire core_rst = ~reset_n; // host reset pin, synchronous
  wire nv_busy;
  wire nv_done;
  wire [15:0] nv_rd;
  wire serial_mode = cfg_r[`TSI_CFG_SERIAL];
  wire style2 = cfg_r[`TSI_CFG_STYLE2];
  wire [7:0] pol_high = cfg_r[`TSI_CFG_POL_HI:`TSI_CFG_POL_LO];
  wire measuring = (state_r == ST_RUN) && measure_request;
  wire phase_end = measuring && (phase_cnt_r == PHASE_CYCLES - 1);

  // apb write strobe and store commit request
  wire wr_acc = psel && penable && pwrite;
  wire commit_req = wr_acc && (paddr == `TSI_OFF_CMD) && pwdata[`TSI_CMD_COMMIT]
                    && (state_r == ST_SETUP) && !nv_busy;

  // channels of one pair: even in phase 0, odd in phase 1
  function [7:0] phase_mask;
    input ph;
    begin
      phase_mask = ph ? 8'haa : 8'h55;
    end
  endfunction

  // true for a mapped register offset
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `TSI_OFF_CFG) || (a == `TSI_OFF_CMD) || (a == `TSI_OFF_STATUS)
                || (a == `TSI_OFF_IRQ_STAT) || (a == `TSI_OFF_IRQ_CLR)
                || (a == `TSI_OFF_IRQ_EN) || (a == `TSI_OFF_CH_EN);
    end
  endfunction

  // non-volatile config store
  tsi_nvm #(
    .WRITE_CYCLES(NV_WRITE_CYCLES)
  ) tsi_nvm_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_req(commit_req),
    .wr_data(cfg_r),
    .busy(nv_busy),
    .done_pulse(nv_done),
    .rd_data(nv_rd)
  );

  // mode sequencing
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD: state_nxt = config_entry_n ? ST_RUN : ST_SETUP;
      ST_RUN: if (!config_entry_n) state_nxt = ST_SETUP;
      ST_SETUP: if (config_entry_n && !nv_busy) state_nxt = ST_RUN;
      default: state_nxt = ST_LOAD;
    endcase
  end

  // per-channel sampling through the shared pin of its pair
  always @* begin
    touch_nxt = touch_r;
    if (phase_end) begin
      touch_nxt = (touch_r & ~phase_mask(phase_r))
                  | (sense_electrode_pin & ch_en_r & phase_mask(phase_r));
    end
    measure_request_done = phase_end && phase_r;
    touch_chg = (touch_nxt != touch_r);
  end

  // events feeding the sticky status
  always @* begin
    events = {`TSI_EV_W{1'b0}};
    events[`TSI_EV_MEASURE_REQUEST_DONE] = measure_request_done;
    events[`TSI_EV_TOUCH_CHG] = touch_chg;
    events[`TSI_EV_NV_DONE] = nv_done;
    events[`TSI_EV_SETUP] = (state_r != ST_SETUP) && (state_nxt == ST_SETUP);
  end

  // state, measurement timing and touch state
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_LOAD;
      phase_cnt_r <= 16'h0000;
      phase_r <= 1'b0;
      touch_r <= 8'h00;
    end else if (core_rst) begin
      state_r <= ST_LOAD;
      phase_cnt_r <= 16'h0000;
      phase_r <= 1'b0;
      touch_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      touch_r <= touch_nxt;
      if (!measuring) begin
        phase_cnt_r <= 16'h0000;
        phase_r <= 1'b0;
      end else if (phase_end) begin
        phase_cnt_r <= 16'h0000;
        phase_r <= ~phase_r;
      end else begin
        phase_cnt_r <= phase_cnt_r + 16'h0001;
      end
    end
  end

  // all four shared charge pins driven high while measuring
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shared_charge_pin_out <= 4'h0;
      shared_charge_pin_oe <= 4'h0;
    end else begin
      shared_charge_pin_out <= measuring ? 4'hf : 4'h0;
      shared_charge_pin_oe <= measuring ? 4'hf : 4'h0;
    end
  end

  // config: loaded from store, then software-writable
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= `TSI_CFG_RESET;
      ch_en_r <= `TSI_CH_EN_RESET;
      irq_en_r <= {`TSI_EV_W{1'b0}};
    end else if (core_rst) begin
      cfg_r <= `TSI_CFG_RESET;
      ch_en_r <= `TSI_CH_EN_RESET;
      irq_en_r <= {`TSI_EV_W{1'b0}};
    end else begin
      if (state_r == ST_LOAD) begin
        cfg_r <= nv_rd;
      end else if (wr_acc && paddr == `TSI_OFF_CFG && !nv_busy) begin
        cfg_r <= pwdata[15:0];
      end
      if (wr_acc && paddr == `TSI_OFF_CH_EN) begin
        ch_en_r <= pwdata[7:0];
      end
      if (wr_acc && paddr == `TSI_OFF_IRQ_EN) begin
        irq_en_r <= pwdata[`TSI_EV_W-1:0];
      end
    end
  end

  // sticky interrupt status, set beats clear
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= {`TSI_EV_W{1'b0}};
    end else if (core_rst) begin
      irq_stat_r <= {`TSI_EV_W{1'b0}};
    end else begin
      if (wr_acc && paddr == `TSI_OFF_IRQ_CLR) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[`TSI_EV_W-1:0]) | events;
      end else begin
        irq_stat_r <= irq_stat_r | events;
      end
    end
  end

  // level interrupt from enabled sticky bits
  assign irq = |(irq_stat_r & irq_en_r);

  // serial notification latch, cleared when host selects the link
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ind_pend_r <= 1'b0;
    end else if (core_rst || state_r != ST_RUN || !serial_mode) begin
      ind_pend_r <= 1'b0;
    end else if (style2 ? touch_chg : measure_request_done) begin
      ind_pend_r <= 1'b1;
    end else if (!serial_select_n) begin
      ind_pend_r <= 1'b0;
    end
  end

  // status indicator and channel outputs
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_indicator_out <= 1'b0;
      channel_result_out <= 8'h00;
    end else if (core_rst) begin
      status_indicator_out <= 1'b0;
      channel_result_out <= 8'h00;
    end else begin
      case (state_r)
        ST_SETUP: status_indicator_out <= !nv_busy && !commit_req;
        ST_RUN: status_indicator_out <= serial_mode ? ind_pend_r : (|touch_r);
        default: status_indicator_out <= 1'b0;
      endcase
      if (state_r == ST_RUN && !serial_mode) begin
        channel_result_out <= ~(touch_r ^ pol_high);
      end else begin
        channel_result_out <= ~pol_high; // idle level of each polarity
      end
    end
  end

  // status word for reads
  always @* begin
    status_word = 32'h0000_0000;
    status_word[1:0] = state_r;
    status_word[2] = nv_busy;
    status_word[3] = measuring;
    status_word[4] = phase_r;
    status_word[5] = status_indicator_out;
    status_word[15:8] = touch_r;
    status_word[19:16] = shared_charge_pin_in; // read-back of pair pins
  end

  // apb: zero wait, error on unmapped offsets
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);

  // read data mux
  always @* begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        `TSI_OFF_CFG: prdata = {16'h0000, cfg_r};
        `TSI_OFF_STATUS: prdata = status_word;
        `TSI_OFF_IRQ_STAT: prdata = {{(32-`TSI_EV_W){1'b0}}, irq_stat_r};
        `TSI_OFF_IRQ_EN: prdata = {{(32-`TSI_EV_W){1'b0}}, irq_en_r};
        `TSI_OFF_CH_EN: prdata = {24'h000000, ch_en_r};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- tsi_defs.vh ----
`ifndef TSI_DEFS_VH
`define TSI_DEFS_VH

// channel geometry
`define TSI_NUM_CH 8
`define TSI_NUM_PAIR 4

// apb register byte offsets
`define TSI_OFF_CFG 8'h00
`define TSI_OFF_CMD 8'h04
`define TSI_OFF_STATUS 8'h08
`define TSI_OFF_IRQ_STAT 8'h0c
`define TSI_OFF_IRQ_CLR 8'h10
`define TSI_OFF_IRQ_EN 8'h14
`define TSI_OFF_CH_EN 8'h18

// configuration word fields
`define TSI_CFG_SERIAL 0
`define TSI_CFG_STYLE2 1
`define TSI_CFG_POL_LO 8
`define TSI_CFG_POL_HI 15
`define TSI_CFG_RESET 16'hff00
`define TSI_CH_EN_RESET 8'hff

// command register bits
`define TSI_CMD_COMMIT 0

// interrupt event bits
`define TSI_EV_MEASURE_REQUEST_DONE 0
`define TSI_EV_TOUCH_CHG 1
`define TSI_EV_NV_DONE 2
`define TSI_EV_SETUP 3
`define TSI_EV_W 4

// timing: clock period and phase and write times in ns
`define TSI_CLK_NS 100
`define TSI_PHASE_NS 2000
`define TSI_NV_WRITE_NS 5000000

`endif

// ---- tsi_nvm.v ----
`include "tsi_defs.vh"
`default_nettype none

// non-volatile config store; array loaded with TSI_CFG_RESET only by power-on rst
module tsi_nvm #(
  parameter WRITE_CYCLES = 50000
) (
  // clock and power-on reset
  input wire sys_clk,
  input wire rst,
  // write port
  input wire wr_req,
  input wire [15:0] wr_data,
  output wire busy,
  output reg done_pulse,
  // read port
  output reg [15:0] rd_data
);

  reg [15:0] store_r;
  reg [31:0] cnt_r;
  reg [15:0] pend_r;

  assign busy = (cnt_r != 32'h0000_0000);

  // write takes WRITE_CYCLES before the word lands
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      store_r <= `TSI_CFG_RESET;
      cnt_r <= 32'h0000_0000;
      pend_r <= 16'h0000;
      done_pulse <= 1'b0;
      rd_data <= `TSI_CFG_RESET;
    end else begin
      done_pulse <= 1'b0;
      rd_data <= store_r;
      if (busy) begin
        cnt_r <= cnt_r - 32'h0000_0001;
        if (cnt_r == 32'h0000_0001) begin
          store_r <= pend_r;
          done_pulse <= 1'b1;
        end
      end else if (wr_req) begin
        cnt_r <= WRITE_CYCLES;
        pend_r <= wr_data;
      end
    end
  end

endmodule

`default_nettype wire

// ---- tsi_top_properties.sv ----
`default_nettype none
module tsi_top_properties #(
  parameter NV_WRITE_CYCLES = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // host pins
  input wire logic measure_request,
  input wire logic config_entry_n,
  input wire logic reset_n,
  // outputs
  input wire logic [3:0] shared_charge_pin_out,
  input wire logic [3:0] shared_charge_pin_oe,
  input wire logic status_indicator_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int setup_cnt_r;
  // cycles spent with config entry held low
  always @(posedge sys_clk or posedge rst) begin
    if (rst) setup_cnt_r <= 0;
    else if (config_entry_n || !reset_n) setup_cnt_r <= 0;
    else if (setup_cnt_r < 15) setup_cnt_r <= setup_cnt_r + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_zero_wait: assert property (psel && penable |-> pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h18 |-> pslverr) else $error("no pslverr");
  a_mapped_ok: assert property (psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("stray pslverr");
  a_cmd_reads_zero: assert property (psel && !pwrite && paddr == 8'h04 |-> prdata == 32'h0)
    else $error("command word not zero");
  a_standby_halt: assert property (!measure_request [*3] |-> shared_charge_pin_oe == 4'h0)
    else $error("measuring in standby");
  a_host_reset: assert property (!reset_n |=> !status_indicator_out && shared_charge_pin_oe == 4'h0)
    else $error("host reset ignored");
  a_pair_pins: assert property (shared_charge_pin_oe == shared_charge_pin_out)
    else $error("pair pin mismatch");
  a_setup_ready: assert property ($fell(config_entry_n) && reset_n |-> ##[1:6] status_indicator_out)
    else $error("no ready on setup");
  a_nv_write_low: assert property (psel && penable && pwrite && paddr == 8'h04 && pwdata[0] &&
    setup_cnt_r > 4 && status_indicator_out |=> ##1 !status_indicator_out [*8] ##[1:1000] status_indicator_out)
    else $error("indicator not low in write");
endmodule
bind tsi_top tsi_top_properties #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) tsi_top_properties_i (
  .sys_clk(sys_clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .measure_request(measure_request),
  .config_entry_n(config_entry_n),
  .reset_n(reset_n),
  .shared_charge_pin_out(shared_charge_pin_out),
  .shared_charge_pin_oe(shared_charge_pin_oe),
  .status_indicator_out(status_indicator_out)
);
`default_nettype wire

// ---- tsi_host_model.sv ----
`default_nettype none
// host side: drives control pins, serves the indicator
module tsi_host_model #(
  parameter int DELAY = 3
) (
  // clock
  input wire logic sys_clk,
  // device status
  input wire logic status_indicator_out,
  // control pins
  output logic measure_request,
  output logic config_entry_n,
  output logic reset_n,
  output logic serial_select_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt = 0;
  int rises = 0;
  logic serve = 1'b0;
  logic ind_q = 1'b0;
  logic measure_request_want = 1'b0;
  logic setup_want = 1'b0;
  logic hreset_want = 1'b0;
  // pins follow what the bench asks for, changed just after an edge
  always @(posedge sys_clk) begin
    measure_request <= measure_request_want;
    config_entry_n <= !setup_want;
    reset_n <= !hreset_want;
  end
  // count notices, select the link when wait_cnt, counting high samples and cleared only on select, reaches DELAY
  always @(posedge sys_clk) begin
    ind_q <= status_indicator_out;
    if (status_indicator_out && !ind_q) rises <= rises + 1;
    if (serve && status_indicator_out && serial_select_n) begin
      if (wait_cnt == DELAY) begin
        serial_select_n <= 1'b0;
        wait_cnt <= 0;
      end else wait_cnt <= wait_cnt + 1;
    end else serial_select_n <= 1'b1;
  end
endmodule
`default_nettype wire

// ---- tsi_tb_top.sv ----
`default_nettype none
module tsi_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NV = 20;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, status_indicator_out, se;
  logic [7:0] paddr, sense_electrode_pin, channel_result_out;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] shared_charge_pin_in, shared_charge_pin_out, shared_charge_pin_oe;
  wire logic measure_request, config_entry_n, reset_n, serial_select_n;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, k;
  tsi_top #(.NV_WRITE_CYCLES(NV)) tsi_top_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .measure_request(measure_request),
    .config_entry_n(config_entry_n),
    .reset_n(reset_n),
    .serial_select_n(serial_select_n),
    .sense_electrode_pin(sense_electrode_pin),
    .shared_charge_pin_in(shared_charge_pin_in),
    .shared_charge_pin_out(shared_charge_pin_out),
    .shared_charge_pin_oe(shared_charge_pin_oe),
    .channel_result_out(channel_result_out),
    .status_indicator_out(status_indicator_out),
    .irq(irq)
  );
  tsi_host_model tsi_host_model_i (
    .sys_clk(sys_clk),
    .status_indicator_out(status_indicator_out),
    .measure_request(measure_request),
    .config_entry_n(config_entry_n),
    .reset_n(reset_n),
    .serial_select_n(serial_select_n)
  );
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task finish_test();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wt(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // one apb transfer, entered just after an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sense_electrode_pin = 8'h00;
    shared_charge_pin_in = 4'h5;
    wt(8);
    rst <= 1'b0;
    wt(2);
    // reset values and an unmapped place
    apb(0, 8'h00, 0); chk("cfg", rd, 32'hff00);
    apb(0, 8'h18, 0); chk("ch_en", rd, 32'hff);
    apb(0, 8'h04, 0); chk("cmd", rd, 0);
    apb(0, 8'h40, 0); chk("unmapped", se, 1);
    $display("test reset done");
    // normal mode, ch0 active low, ch0 and ch7 touched
    apb(1, 8'h14, 32'hf);
    apb(1, 8'h00, 32'hfe00);
    tsi_host_model_i.measure_request_want <= 1'b1;
    sense_electrode_pin <= 8'h81;
    wt(100);
    apb(0, 8'h08, 0); chk("touch", rd[15:8], 8'h81);
    chk("pin_back", rd[19:16], 4'h5);
    chk("pins_on", shared_charge_pin_oe, 4'hf);
    chk("outs", channel_result_out, 8'h80);
    chk("ind", status_indicator_out, 1);
    chk("irq", irq, 1);
    apb(1, 8'h18, 32'h1);
    wt(50);
    apb(0, 8'h08, 0); chk("ch_en_off", rd[15:8], 8'h01);
    apb(1, 8'h18, 32'hff);
    tsi_host_model_i.measure_request_want <= 1'b0;
    wt(5);
    chk("standby", shared_charge_pin_oe, 0);
    $display("test normal done");
    // serial style one, host serving
    apb(1, 8'h00, 32'hff01);
    tsi_host_model_i.serve <= 1'b1;
    tsi_host_model_i.measure_request_want <= 1'b1;
    wt(50);
    n = tsi_host_model_i.rises;
    wt(400);
    chk("notices1", tsi_host_model_i.rises - n, 10);
    chk("idle_outs", channel_result_out, 8'h00);
    // serial style two, notice on touch change only
    apb(1, 8'h00, 32'hff03);
    apb(1, 8'h10, 32'hf);
    wt(60);
    n = tsi_host_model_i.rises;
    wt(400);
    chk("notices2", tsi_host_model_i.rises - n, 0);
    sense_electrode_pin <= 8'h80;
    wt(100);
    chk("notices3", tsi_host_model_i.rises - n, 1);
    chk("irq_on", irq, 1);
    apb(1, 8'h14, 32'h0); chk("irq_mask", irq, 0);
    apb(0, 8'h0c, 0); chk("stat_chg", rd[1], 1);
    apb(1, 8'h10, 32'h2);
    apb(0, 8'h0c, 0); chk("stat_clr", rd[1], 0);
    $display("test serial done");
    // setup mode, commit to the store
    tsi_host_model_i.serve <= 1'b0;
    tsi_host_model_i.setup_want <= 1'b1;
    wt(10);
    chk("setup_ind", status_indicator_out, 1);
    apb(1, 8'h04, 32'h1);
    wt(2);
    chk("nv_low", status_indicator_out, 0);
    apb(1, 8'h00, 32'h0);
    k = 0;
    while (status_indicator_out !== 1'b1 && k < 200) begin
      wt(1);
      k++;
    end
    chk("nv_done", status_indicator_out, 1);
    apb(0, 8'h0c, 0); chk("stat_nv", rd[3:2], 2'h3);
    apb(0, 8'h00, 0); chk("cfg_busy", rd, 32'hff03);
    // host reset keeps the stored mode
    tsi_host_model_i.setup_want <= 1'b0;
    tsi_host_model_i.hreset_want <= 1'b1;
    wt(3);
    chk("hreset", status_indicator_out, 0);
    tsi_host_model_i.hreset_want <= 1'b0;
    wt(3);
    apb(0, 8'h00, 0); chk("nv_store", rd, 32'hff03);
    $display("test setup done");
    finish_test();
  end
endmodule
`default_nettype wire
